// ==== arc_pkg.sv ====
// Purpose: constants and carrier types for the general configuration register bank
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are byte addresses; the general window is C0h to CCh, control registers sit at D0h to D2h
package arc_pkg;
	localparam logic [7:0] ARC_WIN_LO = 8'hC0;
	localparam logic [7:0] ARC_WIN_HI = 8'hCC;
	localparam logic [7:0] ARC_OFF_STAT = 8'hC0;
	localparam logic [7:0] ARC_OFF_MASK = 8'hC1;
	localparam logic [7:0] ARC_OFF_GENERAL_CONFIG_REG = 8'hC2;
	localparam logic [7:0] ARC_OFF_AUX_PIN_CONFIG = 8'hC3;
	localparam logic [7:0] ARC_OFF_AOE = 8'hC4;
	localparam logic [7:0] ARC_OFF_AVAL = 8'hC5;
	localparam logic [7:0] ARC_OFF_SIN1 = 8'hC6;
	localparam logic [7:0] ARC_OFF_SIN2 = 8'hC7;
	localparam logic [7:0] ARC_OFF_SOUT1 = 8'hC8;
	localparam logic [7:0] ARC_OFF_SOUT2 = 8'hC9;
	localparam logic [7:0] ARC_OFF_SERIAL_PORT_CONFIG = 8'hCA;
	localparam logic [7:0] ARC_OFF_STROBE_CONFIG = 8'hCB;
	localparam logic [7:0] ARC_OFF_TIM2 = 8'hCC;
	// control registers outside the general window
	localparam logic [7:0] ARC_OFF_CTRL = 8'hD0;
	localparam logic [7:0] ARC_OFF_DTIM = 8'hD1;
	localparam logic [7:0] ARC_OFF_DMODE = 8'hD2;
	localparam logic [7:0] ARC_RST_ZERO = 8'h00;
	localparam logic [7:0] ARC_RST_MASK = 8'hC0;
	localparam logic [7:0] ARC_RST_AOE = 8'hFC;
	localparam logic [7:0] ARC_AUX_MASK = 8'hFC;
	// ctrl bit positions
	localparam int ARC_CB_PDN = 0;
	localparam int ARC_CB_TSF = 1;
	localparam int ARC_CB_RSS = 2;
	localparam int ARC_CB_SPU = 3;
	localparam int ARC_CB_TERM = 4;
	localparam int ARC_DM_TMD = 0;
	// stat bits 7/6 are the external irq inputs 1/0
	localparam int ARC_ST_EXT0 = 6;
	localparam int ARC_ST_EXT1 = 7;
	localparam int ARC_AUX_PIN_CONFIG_EL0 = 0;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} arc_req_t;

	typedef struct packed {
		logic [7:0] stat;
		logic [7:0] mask;
		logic [7:0] general_config_reg;
		logic [7:0] aux_pin_config;
		logic [7:0] aux_output_enable;
		logic [7:0] aval;
		logic [7:0] sin1;
		logic [7:0] sin2;
		logic [7:0] sout1;
		logic [7:0] sout2;
		logic [7:0] serial_port_config;
		logic [7:0] strobe_config;
		logic [7:0] tim2;
		logic [7:0] ctrl;
		logic [7:0] dtim;
		logic [7:0] dmode;
		logic [7:0] rdata;
		logic [1:0] ext_prev;
	} arc_state_t;
endpackage

// ==== arc_regs.sv ====
// Purpose: reset defaults, decode and retention of the general configuration bank
// Assumes: one clock, synchronous active-high reset, strobes one cycle long
// Notes: power-down gates event capture, the interrupt output and the internal clock enable; host writes still land
//
// Behaviour
// - general registers decode inside window C0h to CCh only.
// - general config register resets to 00.
// - top interrupt status resets 00, mask resets C0.
// - aux pin config resets to 00, open drain, low-level inputs.
// - aux output enable resets FC, aux output value resets 00.
// - both serial input slot registers reset to 00.
// - both serial output slot registers reset to 00.
// - serial port config resets to 00.
// - strobe config resets to 00.
// - second timer register resets to 00.
// - power-down switching keeps all register contents and state.
// - power-down stops internal activity and forwards no interrupts.
// - with terminal functions enabled, reset source select enables reset output.
// - D-channel timer register meaning follows the timer mode bit.
// - upstream pull in terminal mode drives upstream data line low.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module arc_regs
	import arc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// events and wake sources
	input wire logic [1:0] external_irq_inputs_i,
	input wire logic wake_i,
	input wire logic watchdog_i,
	// aux pins 7..2 (bits 1..0 unused, tied low)
	input wire logic [7:0] aux_i,
	output logic [7:0] aux_o,
	output logic [7:0] aux_oe_o,
	// upstream data line pull
	output logic upstream_data_line_o,
	output logic upstream_data_line_oe_o,
	// status outputs
	output logic hw_reset_o,
	output logic internal_clk_en_o,
	output logic irq_o,
	output logic [7:0] cfg_general_o,
	output logic [7:0] dchan_timer_o,
	output logic timer_internal_o
);

	////////////////////////////////////////////////////////////////////////////
	arc_state_t r;
	arc_state_t next_r;
	arc_req_t req;
	logic in_win;
	logic pdn;
	logic [1:0] ext_lvl;
	logic [1:0] ext_hit;

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign in_win = (req.addr >= ARC_WIN_LO) && (req.addr <= ARC_WIN_HI);
	assign pdn = r.ctrl[ARC_CB_PDN];

	// inputs are active low; level mode sees the low level, edge mode a falling edge
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ext
			assign ext_lvl[gi] = ~external_irq_inputs_i[gi];
			assign ext_hit[gi] = r.aux_pin_config[ARC_AUX_PIN_CONFIG_EL0 + gi] ?
				(r.ext_prev[gi] & ~external_irq_inputs_i[gi]) : ext_lvl[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [7:0] ev;
		ev = 8'h00;
		next_r = r;
		next_r.rdata = 8'h00;
		next_r.ext_prev = external_irq_inputs_i;
		// no event capture while clocks are gated
		if (!pdn) begin
			ev[ARC_ST_EXT0] = ext_hit[0];
			ev[ARC_ST_EXT1] = ext_hit[1];
		end
		if (req.rd) begin
			if (req.addr == ARC_OFF_STAT) begin
				next_r.rdata = r.stat;
			end else if (req.addr == ARC_OFF_MASK) begin
				next_r.rdata = r.mask;
			end else if (req.addr == ARC_OFF_GENERAL_CONFIG_REG) begin
				next_r.rdata = r.general_config_reg;
			end else if (req.addr == ARC_OFF_AUX_PIN_CONFIG) begin
				next_r.rdata = r.aux_pin_config;
			end else if (req.addr == ARC_OFF_AOE) begin
				next_r.rdata = r.aux_output_enable;
			end else if (req.addr == ARC_OFF_AVAL) begin
				next_r.rdata = (aux_i & ARC_AUX_MASK);
			end else if (req.addr == ARC_OFF_SIN1) begin
				next_r.rdata = r.sin1;
			end else if (req.addr == ARC_OFF_SIN2) begin
				next_r.rdata = r.sin2;
			end else if (req.addr == ARC_OFF_SOUT1) begin
				next_r.rdata = r.sout1;
			end else if (req.addr == ARC_OFF_SOUT2) begin
				next_r.rdata = r.sout2;
			end else if (req.addr == ARC_OFF_SERIAL_PORT_CONFIG) begin
				next_r.rdata = r.serial_port_config;
			end else if (req.addr == ARC_OFF_STROBE_CONFIG) begin
				next_r.rdata = r.strobe_config;
			end else if (req.addr == ARC_OFF_TIM2) begin
				next_r.rdata = r.tim2;
			end else if (req.addr == ARC_OFF_CTRL) begin
				next_r.rdata = r.ctrl;
			end else if (req.addr == ARC_OFF_DTIM) begin
				next_r.rdata = r.dtim;
			end else if (req.addr == ARC_OFF_DMODE) begin
				next_r.rdata = r.dmode;
			end else begin
				next_r.rdata = 8'h00;
			end
		end
		// writes only touch the addressed register; pdn changes nothing else
		if (req.wr) begin
			if (in_win && req.addr == ARC_OFF_STAT) begin
				next_r.stat = r.stat & ~req.wdata;
			end else if (in_win && req.addr == ARC_OFF_MASK) begin
				next_r.mask = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_GENERAL_CONFIG_REG) begin
				next_r.general_config_reg = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_AUX_PIN_CONFIG) begin
				next_r.aux_pin_config = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_AOE) begin
				next_r.aux_output_enable = req.wdata & ARC_AUX_MASK;
			end else if (in_win && req.addr == ARC_OFF_AVAL) begin
				next_r.aval = req.wdata & ARC_AUX_MASK;
			end else if (in_win && req.addr == ARC_OFF_SIN1) begin
				next_r.sin1 = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_SIN2) begin
				next_r.sin2 = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_SOUT1) begin
				next_r.sout1 = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_SOUT2) begin
				next_r.sout2 = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_SERIAL_PORT_CONFIG) begin
				next_r.serial_port_config = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_STROBE_CONFIG) begin
				next_r.strobe_config = req.wdata;
			end else if (in_win && req.addr == ARC_OFF_TIM2) begin
				next_r.tim2 = req.wdata;
			end else if (req.addr == ARC_OFF_CTRL) begin
				next_r.ctrl = req.wdata;
			end else if (req.addr == ARC_OFF_DTIM) begin
				next_r.dtim = req.wdata;
			end else if (req.addr == ARC_OFF_DMODE) begin
				next_r.dmode = req.wdata;
			end
		end
		// set wins over a same-cycle write-one clear
		next_r.stat = next_r.stat | ev;
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			// defaults held until the host writes, except stat, which also sets on captured events
			r.general_config_reg <= ARC_RST_ZERO;
			r.stat <= ARC_RST_ZERO;
			r.mask <= ARC_RST_MASK;
			r.aux_pin_config <= ARC_RST_ZERO;
			r.aux_output_enable <= ARC_RST_AOE;
			r.aval <= ARC_RST_ZERO;
			r.sin1 <= ARC_RST_ZERO;
			r.sin2 <= ARC_RST_ZERO;
			r.sout1 <= ARC_RST_ZERO;
			r.sout2 <= ARC_RST_ZERO;
			r.serial_port_config <= ARC_RST_ZERO;
			r.strobe_config <= ARC_RST_ZERO;
			r.tim2 <= ARC_RST_ZERO;
			r.ctrl <= ARC_RST_ZERO;
			r.dtim <= ARC_RST_ZERO;
			r.dmode <= ARC_RST_ZERO;
			r.rdata <= ARC_RST_ZERO;
			r.ext_prev <= 2'b11;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign rdata_o = r.rdata;
	// aoe bit high means input, so the driver is enabled where it is low
	assign aux_oe_o = ~r.aux_output_enable & ARC_AUX_MASK;
	assign aux_o = r.aval & ~r.aux_output_enable & ARC_AUX_MASK;
	assign upstream_data_line_oe_o = r.ctrl[ARC_CB_SPU] & r.ctrl[ARC_CB_TERM];
	assign upstream_data_line_o = 1'b0;
	// reset sources gated by terminal enable
	assign hw_reset_o = r.ctrl[ARC_CB_TSF] & r.ctrl[ARC_CB_RSS] & (wake_i | watchdog_i);
	// clocks gated and interrupt withheld in power-down
	assign internal_clk_en_o = ~pdn;
	assign irq_o = ~pdn & (|(r.stat & ~r.mask));
	assign cfg_general_o = r.general_config_reg;
	// timer register meaning by mode bit
	assign dchan_timer_o = r.dtim;
	assign timer_internal_o = r.dmode[ARC_DM_TMD];
endmodule

// ==== arc_regs_assertions.sv ====
// Purpose: port-level checks of the general configuration bank
// Assumes: one clock, synchronous active-high reset
// Notes: watches design ports only, inputs and outputs
`timescale 1ns/1ps
module arc_regs_checker
	import arc_pkg::*;
(
	input wire logic ref_clk_i, rst_i, wr_i, rd_i, wake_i, watchdog_i,
	input wire logic [7:0] addr_i, wdata_i, rdata_o, aux_oe_o, cfg_general_o, dchan_timer_o,
	input wire logic upstream_data_line_o, upstream_data_line_oe_o, hw_reset_o,
	input wire logic internal_clk_en_o, irq_o, timer_internal_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	wire logic unmapped = !(addr_i inside {[ARC_WIN_LO:ARC_WIN_HI], [ARC_OFF_CTRL:ARC_OFF_DMODE]});
	////////////////////////////////////////////////////////////////////////////////
	rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
	window_decode_a: assert property (rd_i && unmapped |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	reset_defaults_a: assert property ($fell(rst_i) |-> !irq_o && aux_oe_o == 8'h00 &&
		internal_clk_en_o && cfg_general_o == 8'h00 && dchan_timer_o == 8'h00)
		else $error("reset default wrong");
	general_config_reg_write_a: assert property (wr_i && addr_i == ARC_OFF_GENERAL_CONFIG_REG |=>
		cfg_general_o == $past(wdata_i)) else $error("general_config_reg write lost");
	dtim_write_a: assert property (wr_i && addr_i == ARC_OFF_DTIM |=>
		dchan_timer_o == $past(wdata_i)) else $error("d timer write lost");
	pdn_retain_a: assert property ($changed(internal_clk_en_o) |->
		$stable(cfg_general_o) && $stable(dchan_timer_o)) else $error("power switch lost state");
	pdn_no_irq_a: assert property (!internal_clk_en_o |-> !irq_o) else $error("irq in power-down");
	hw_reset_src_a: assert property (hw_reset_o |-> wake_i || watchdog_i)
		else $error("reset without source");
	pull_low_a: assert property (upstream_data_line_oe_o |-> !upstream_data_line_o)
		else $error("upstream pull not low");
	cover property ($rose(irq_o));
	cover property ($rose(hw_reset_o));
	cover property ($fell(internal_clk_en_o));
endmodule
bind arc_regs arc_regs_checker i_chk(.ref_clk_i, .rst_i, .wr_i, .rd_i, .wake_i, .watchdog_i,
	.addr_i, .wdata_i, .rdata_o, .aux_oe_o, .cfg_general_o, .dchan_timer_o,
	.upstream_data_line_o, .upstream_data_line_oe_o, .hw_reset_o,
	.internal_clk_en_o, .irq_o, .timer_internal_o);

// ==== arc_host.sv ====
// Purpose: host processor model on the register port
// Assumes: strobes launched just after a rising edge
// Notes: returns 1 ns past an edge so callers see settled outputs
`timescale 1ns/1ps
module arc_host
	import arc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [7:0] rdata_i,
	output arc_req_t req_o
);
	initial req_o = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_i);
		req_o.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk_i);
		req_o.rd <= 1'b0;
		#1 d = rdata_i;
	endtask
endmodule

// ==== arc_regs_tb.sv ====
// Purpose: self-checking bench for arc_regs
// Assumes: host model drives the register port
// Notes: expected values come from a byte model of the bank
`timescale 1ns/1ps
module arc_regs_tb;
	import arc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] ext = 2'b11;
	logic wake = 1'b0;
	logic wdog = 1'b0;
	logic [7:0] aux = 8'h00;
	logic [7:0] rdata, aux_o, aux_oe, cfg, dtim, got;
	logic dl, dl_oe, hwr, clk_en, irq, tmr;
	arc_req_t req;
	logic [7:0] m [256];
	int n_errors = 0;
	int checks_done = 0;
	initial forever #2 ref_clk_i = ~ref_clk_i;
	arc_host i_arc_host(.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req));
	arc_regs i_arc_regs(.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(req.addr),
		.wdata_i(req.wdata), .wr_i(req.wr), .rd_i(req.rd), .rdata_o(rdata),
		.external_irq_inputs_i(ext), .wake_i(wake), .watchdog_i(wdog), .aux_i(aux),
		.aux_o(aux_o), .aux_oe_o(aux_oe), .upstream_data_line_o(dl),
		.upstream_data_line_oe_o(dl_oe), .hw_reset_o(hwr), .internal_clk_en_o(clk_en),
		.irq_o(irq), .cfg_general_o(cfg), .dchan_timer_o(dtim), .timer_internal_o(tmr));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] g);
		checks_done++;
		if (g !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, g);
		end
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic rchk(input logic [7:0] a);
		i_arc_host.rd(a, got);
		chk("rdata", (a == ARC_OFF_AVAL) ? (aux & ARC_AUX_MASK) : m[a], got);
	endtask
	// status bits clear on a written one, unmapped writes vanish
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		i_arc_host.wr(a, d);
		if (a == ARC_OFF_STAT) m[a] &= ~d;
		// aux pins 1..0 do not exist, so their enable and value bits never store
		else if (a == ARC_OFF_AOE || a == ARC_OFF_AVAL) m[a] = d & ARC_AUX_MASK;
		else if (a inside {[ARC_WIN_LO:ARC_WIN_HI], [ARC_OFF_CTRL:ARC_OFF_DMODE]}) m[a] = d;
	endtask
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		foreach (m[i]) m[i] = 8'h00;
		m[ARC_OFF_MASK] = ARC_RST_MASK;
		m[ARC_OFF_AOE] = ARC_RST_AOE;
	endtask
	task automatic scan();
		for (int a = 'hBE; a <= 'hD4; a++) rchk(8'(a));
		chk("cfg", m[ARC_OFF_GENERAL_CONFIG_REG], cfg);
		chk("dtim", m[ARC_OFF_DTIM], dtim);
		chk("aux_oe", ~m[ARC_OFF_AOE] & ARC_AUX_MASK, aux_oe);
		chk("aux_o", m[ARC_OFF_AVAL] & ~m[ARC_OFF_AOE] & ARC_AUX_MASK, aux_o);
		chk("tmd", {7'h00, m[ARC_OFF_DMODE][ARC_DM_TMD]}, {7'h00, tmr});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(14007));
		aux <= 8'($urandom);
		do_reset();
		scan();
		for (int a = 'hC0; a <= 'hD2; a++) if (a != 'hD0) w(8'(a), 8'($urandom));
		scan();
		w(ARC_OFF_AUX_PIN_CONFIG, 8'h00);
		w(ARC_OFF_MASK, 8'h00);
		ext <= 2'b10;
		m[ARC_OFF_STAT][ARC_ST_EXT0] = 1'b1;
		rchk(ARC_OFF_STAT);
		chk("irq", 8'h01, {7'h00, irq});
		w(ARC_OFF_MASK, 8'h40);
		chk("irq", 8'h00, {7'h00, irq});
		w(ARC_OFF_CTRL, 8'h01);
		w(ARC_OFF_MASK, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
		chk("clk_en", 8'h00, {7'h00, clk_en});
		rchk(ARC_OFF_GENERAL_CONFIG_REG);
		w(ARC_OFF_CTRL, 8'h00);
		chk("irq", 8'h01, {7'h00, irq});
		ext <= 2'b11;
		w(ARC_OFF_STAT, 8'h40);
		chk("irq", 8'h00, {7'h00, irq});
		w(ARC_OFF_CTRL, 8'h06);
		wake <= 1'b1;
		#1 chk("hw_reset", 8'h01, {7'h00, hwr});
		wake <= 1'b0;
		wdog <= 1'b1;
		#1 chk("hw_reset", 8'h01, {7'h00, hwr});
		w(ARC_OFF_CTRL, 8'h02);
		chk("hw_reset", 8'h00, {7'h00, hwr});
		w(ARC_OFF_CTRL, 8'h18);
		chk("pull_oe", 8'h01, {7'h00, dl_oe});
		chk("pull", 8'h00, {7'h00, dl});
		w(ARC_OFF_CTRL, 8'h08);
		chk("pull_oe", 8'h00, {7'h00, dl_oe});
		do_reset();
		scan();
		print_verdict();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		n_errors++;
		print_verdict();
	end
endmodule
